// [design/gfm_top.sv]
// per-pin function multiplexer for sixteen general-purpose pins with apb registers
//
// Contract
// RL1: invert bit flips output, not for 0x000/0x002
// RL2: code 0x000 selects pin's own alternate
// RL3: resets to 0x001; level out or input
// RL4: code 0x002 hands pin to dsp io
// RL5: code 0x003 outputs interrupt_request_one, pins 1-8
// RL6: interrupt_request_one always drives dedicated interrupt pin
// RL7: 0x010 loop clock, 0x018 lock, pins 1-8
// RL8: 0x048 sysclk derived clock, pins 1-8
// RL9: 0x080/0x081 pwm outputs on all pins
// RL10: 0x08c, 0x090, 0x092 detect status, pins 1-8
// RL11: 0x158 event fifo not-empty, pins 1-8
// RL12: 0x230-0x233 alarm pulses, all pins
// RL13: 0x250/0x251 timer pulses, all pins
// RL14: 0x608-0x60b slave selects, pins 1-10
// RL15: fixed alternate function per pin table
// RL16: alternate fixes direction and cmos driver
// RL17: status shows debounced input, no inversion
// RL18: latched rise and fall flags per pin
// RL19: output level bits read back zero
// RL20: software uses source 00 for loop clock
// RL21: pin clock equals loop over divider; divider below 2 gives no pin clock
// RL22: software disables before changing divider
// RL23: enable bit gates loop clock, resets 0
// RL24: invalid code drives static low
`timescale 1ns/100ps
module gfm_top
  import gfm_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [15:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [15:0] PIN_IN,
  output logic [15:0]      PIN_OUT,
  output logic [15:0]      PIN_OE_N,
  output logic [15:0]      PIN_ODRAIN,
  input  wire logic [15:0] PIN_DEBOUNCED,
  input  wire logic [15:0] ALT_OUT,
  input  wire logic [15:0] ALT_OE,
  input  wire logic [15:0] DSP_OUT,
  input  wire logic [15:0] DSP_OE,
  input  wire logic        INTERRUPT_REQUEST_ONE_IN,
  output logic             IRQ_PIN,
  input  wire logic        LOOP_TICK,
  input  wire logic        LOOP_LOCK,
  input  wire logic        SYSCLK_OUT_IN,
  input  wire logic [1:0]  PWM_IN,
  input  wire logic        SIGDET_IN,
  input  wire logic [1:0]  US_DET_IN,
  input  wire logic        EVLOG_NOT_EMPTY,
  input  wire logic [3:0]  ALARM_PULSE,
  input  wire logic [1:0]  TIMER_PULSE,
  input  wire logic [3:0]  SLAVE_SEL
);
  // per-pin control register
  logic [9:0]  fn_q    [NUM_PINS];
  logic [9:0]  fn_d    [NUM_PINS];
  logic [15:0] dir_q;
  logic [15:0] dir_d;
  logic [15:0] lvl_q;
  logic [15:0] lvl_d;
  logic [15:0] od_q;
  logic [15:0] od_d;
  logic [15:0] inv_q;
  logic [15:0] inv_d;
  // loop clock register
  logic [1:0]  src_q;
  logic [1:0]  src_d;
  logic [6:0]  div_q;
  logic [6:0]  div_d;
  logic        en_q;
  logic        en_d;
  // bus state
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        ready_q;
  logic        ready_d;
  logic        err_q;
  logic        err_d;
  // pin outputs
  logic [15:0] out_q;
  logic [15:0] out_d;
  logic [15:0] oen_q;
  logic [15:0] oen_d;
  logic [15:0] odr_q;
  logic [15:0] odr_d;
  logic        irq_q;
  logic [15:0] status_q;
  logic [31:0] flag_clr;
  logic [31:0] flags;
  logic        loop_clk;
  logic        access;
  logic        hit_pin;
  logic [3:0]  pin_idx;
  logic [15:0] pin_off;

  // selected function value for a pin; invalid code or pin gives valid=0
  function automatic logic [1:0] select_fn(input logic [9:0] fn, input int pin,
                                           input logic lclk, input logic [31:0] sig);
    logic low_ok;
    logic ss_ok;
    logic v;
    logic ok;
    low_ok = (pin <= LOW_GROUP_LAST);
    ss_ok  = (pin <= SS_GROUP_LAST);
    v      = 1'b0;
    ok     = 1'b0;
    case (fn)
      FN_IRQ:        begin ok = low_ok; v = sig[0];  end // RL5
      FN_LOOPCLK:    begin ok = low_ok; v = lclk;    end // RL7
      FN_LOCK:       begin ok = low_ok; v = sig[1];  end // RL7
      FN_SYSCLK_OUT: begin ok = low_ok; v = sig[2];  end // RL8
      FN_PWM1:       begin ok = 1'b1;   v = sig[3];  end // RL9
      FN_PWM2:       begin ok = 1'b1;   v = sig[4];  end // RL9
      FN_SIGDET:     begin ok = low_ok; v = sig[5];  end // RL10
      FN_US1:        begin ok = low_ok; v = sig[6];  end // RL10
      FN_US2:        begin ok = low_ok; v = sig[7];  end // RL10
      FN_EVLOG:      begin ok = low_ok; v = sig[8];  end // RL11
      FN_TIMER1:     begin ok = 1'b1;   v = sig[9];  end // RL13
      FN_TIMER2:     begin ok = 1'b1;   v = sig[10]; end // RL13
      default: begin
        if (fn >= FN_ALARM1 && fn <= FN_ALARM4) begin
          ok = 1'b1; // RL12
          v  = sig[11 + int'(fn[1:0])];
        end else if (fn >= FN_SS1 && fn <= FN_SS4) begin
          ok = ss_ok; // RL14
          v  = sig[15 + int'(fn[1:0])];
        end
      end
    endcase
    select_fn = {ok, v};
  endfunction

  assign access  = PSEL && PENABLE && !ready_q;
  assign pin_off = PADDR - ADDR_PIN_BASE;
  assign pin_idx = pin_off[5:2];
  assign hit_pin = (PADDR >= ADDR_PIN_BASE) && (pin_off < 16'h0040) && (PADDR[1:0] == 2'h0);

  // register writes and reads; one wait state so reads see settled state
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      fn_d[i] = fn_q[i];
    end
    dir_d    = dir_q;
    lvl_d    = lvl_q;
    od_d     = od_q;
    inv_d    = inv_q;
    src_d    = src_q;
    div_d    = div_q;
    en_d     = en_q;
    rdata_d  = 32'h0000_0000;
    ready_d  = access;
    err_d    = 1'b0;
    flag_clr = 32'h0000_0000;
    if (access) begin
      if (PADDR == ADDR_LOOPCLK) begin
        if (PWRITE) begin
          src_d = PWDATA[POS_SRC_LO +: 2]; // RL20
          div_d = PWDATA[POS_DIV_LO +: 7]; // RL21
          en_d  = PWDATA[POS_EN];          // RL23
        end
        rdata_d[POS_SRC_LO +: 2] = src_q;
        rdata_d[POS_DIV_LO +: 7] = div_q;
        rdata_d[POS_EN]          = en_q;
      end else if (PADDR == ADDR_STATUS) begin
        rdata_d[15:0] = status_q; // RL17
      end else if (PADDR == ADDR_EDGE_FLAGS) begin
        if (PWRITE) begin
          flag_clr = PWDATA; // RL18
        end
        rdata_d = flags;
      end else if (PADDR == ADDR_MISC) begin
        rdata_d[0] = irq_q;
      end else if (hit_pin) begin
        if (PWRITE) begin
          fn_d[pin_idx]  = PWDATA[POS_FN_LO +: FN_W];
          dir_d[pin_idx] = PWDATA[POS_DIR];
          lvl_d[pin_idx] = PWDATA[POS_LVL];
          od_d[pin_idx]  = PWDATA[POS_ODRAIN];
          inv_d[pin_idx] = PWDATA[POS_INV];
        end
        // level bit stays zero on read
        rdata_d[POS_FN_LO +: FN_W] = fn_q[pin_idx]; // RL19
        rdata_d[POS_DIR]           = dir_q[pin_idx];
        rdata_d[POS_ODRAIN]        = od_q[pin_idx];
        rdata_d[POS_INV]           = inv_q[pin_idx];
      end else begin
        err_d = 1'b1;
      end
    end
  end

  // pin multiplexing; oe active low
  always_comb begin
    logic [31:0] sig;
    logic [1:0]  sel;
    logic [1:0]  kind;
    sig  = {13'h0000, SLAVE_SEL, ALARM_PULSE, TIMER_PULSE, EVLOG_NOT_EMPTY,
            US_DET_IN, SIGDET_IN, PWM_IN, SYSCLK_OUT_IN, LOOP_LOCK, INTERRUPT_REQUEST_ONE_IN};
    sel  = 2'h0;
    kind = KIND_NONE;
    for (int i = 0; i < NUM_PINS; i++) begin
      kind     = ALT_KIND[2*i +: 2];
      out_d[i] = 1'b0;
      oen_d[i] = 1'b1;
      odr_d[i] = 1'b0;
      if (fn_q[i] == FN_ALT) begin
        if (kind != KIND_NONE) begin // RL15
          out_d[i] = ALT_OUT[i]; // RL2
          // direction from the table, not from the direction bit
          oen_d[i] = (kind == KIND_IN) || (kind == KIND_BIDIR && !ALT_OE[i]); // RL16
        end
      end else if (fn_q[i] == FN_DSPIO) begin
        out_d[i] = DSP_OUT[i]; // RL4
        oen_d[i] = !DSP_OE[i]; // RL4
      end else if (fn_q[i] == FN_GPIO) begin
        out_d[i] = lvl_q[i] ^ inv_q[i]; // RL3 RL1
        oen_d[i] = dir_q[i]; // RL3
        odr_d[i] = od_q[i];
      end else begin
        sel = select_fn(fn_q[i], i, loop_clk, sig);
        // invalid selection gives a low level, never inverted; oe still follows the direction bit
        out_d[i] = sel[1] & (sel[0] ^ inv_q[i]); // RL24 RL1
        oen_d[i] = dir_q[i];
        odr_d[i] = od_q[i];
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        fn_q[i] <= RST_FN; // RL3
      end
      dir_q    <= {NUM_PINS{RST_DIR}};
      lvl_q    <= 16'h0000;
      od_q     <= 16'h0000;
      inv_q    <= 16'h0000;
      src_q    <= RST_SRC;
      div_q    <= RST_DIV; // RL21
      en_q     <= 1'b0; // RL23
      rdata_q  <= 32'h0000_0000;
      ready_q  <= 1'b0;
      err_q    <= 1'b0;
      out_q    <= 16'h0000;
      oen_q    <= 16'hffff;
      odr_q    <= 16'h0000;
      irq_q    <= 1'b0;
      status_q <= 16'h0000;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        fn_q[i] <= fn_d[i];
      end
      dir_q    <= dir_d;
      lvl_q    <= lvl_d;
      od_q     <= od_d;
      inv_q    <= inv_d;
      src_q    <= src_d;
      div_q    <= div_d;
      en_q     <= en_d;
      rdata_q  <= rdata_d;
      ready_q  <= ready_d;
      err_q    <= err_d;
      out_q    <= out_d;
      oen_q    <= oen_d;
      odr_q    <= odr_d;
      irq_q    <= INTERRUPT_REQUEST_ONE_IN; // RL6
      status_q <= PIN_DEBOUNCED; // RL17
    end
  end

  // divider only shapes the pin copy; the loop itself is untouched
  gfm_loopclk_div u_div (
    .clk       (CLK_SYS),
    .rst_n     (RSTN),
    .loop_tick (LOOP_TICK),
    .enable    (en_q && src_q == SRC_LOOP && div_q >= 7'h02), // RL23 RL21
    .divider   (div_q),
    .clk_out   (loop_clk)
  );

  gfm_edge_flags u_flags (
    .clk   (CLK_SYS),
    .rst_n (RSTN),
    .level (PIN_DEBOUNCED),
    .clear (flag_clr),
    .flags (flags)
  );

  assign PRDATA     = rdata_q;
  assign PREADY     = ready_q;
  assign PSLVERR    = err_q;
  assign PIN_OUT    = out_q;
  assign PIN_OE_N   = oen_q;
  assign PIN_ODRAIN = odr_q;
  assign IRQ_PIN    = irq_q;
endmodule

// [design/gfm_pkg.sv]
// package: register map, field layout, function codes for the pin multiplexer
package gfm_pkg;
  localparam int          NUM_PINS          = 16;
  localparam int          FN_W              = 10;
  // register byte addresses
  localparam logic [15:0] ADDR_LOOPCLK      = 16'h1ca0;
  localparam logic [15:0] ADDR_STATUS       = 16'h0c00;
  localparam logic [15:0] ADDR_PIN_BASE     = 16'h0c08;
  localparam logic [15:0] ADDR_EDGE_FLAGS   = 16'h0d00;
  localparam logic [15:0] ADDR_MISC         = 16'h0d04;
  // pin control register fields
  localparam int          POS_DIR           = 31;
  localparam int          POS_LVL           = 15;
  localparam int          POS_ODRAIN        = 14;
  localparam int          POS_INV           = 12;
  localparam int          POS_FN_LO         = 0;
  localparam logic        RST_DIR           = 1'b1;
  localparam logic [9:0]  RST_FN            = 10'h001;
  // loop clock register fields
  localparam int          POS_SRC_LO        = 10;
  localparam int          POS_DIV_LO        = 1;
  localparam int          POS_EN            = 0;
  localparam logic [1:0]  RST_SRC           = 2'h3;
  localparam logic [6:0]  RST_DIV           = 7'h02;
  localparam logic [1:0]  SRC_LOOP          = 2'h0;
  // function codes
  localparam logic [9:0]  FN_ALT            = 10'h000;
  localparam logic [9:0]  FN_GPIO           = 10'h001;
  localparam logic [9:0]  FN_DSPIO          = 10'h002;
  localparam logic [9:0]  FN_IRQ            = 10'h003;
  localparam logic [9:0]  FN_LOOPCLK        = 10'h010;
  localparam logic [9:0]  FN_LOCK           = 10'h018;
  localparam logic [9:0]  FN_SYSCLK_OUT     = 10'h048;
  localparam logic [9:0]  FN_PWM1           = 10'h080;
  localparam logic [9:0]  FN_PWM2           = 10'h081;
  localparam logic [9:0]  FN_SIGDET         = 10'h08c;
  localparam logic [9:0]  FN_US1            = 10'h090;
  localparam logic [9:0]  FN_US2            = 10'h092;
  localparam logic [9:0]  FN_EVLOG          = 10'h158;
  localparam logic [9:0]  FN_ALARM1         = 10'h230;
  localparam logic [9:0]  FN_ALARM4         = 10'h233;
  localparam logic [9:0]  FN_TIMER1         = 10'h250;
  localparam logic [9:0]  FN_TIMER2         = 10'h251;
  localparam logic [9:0]  FN_SS1            = 10'h608;
  localparam logic [9:0]  FN_SS4            = 10'h60b;
  // pin ranges (zero based index)
  localparam int          LOW_GROUP_LAST    = 7;
  localparam int          SS_GROUP_LAST     = 9;
  // alternate function direction kinds per pin: 0 none, 1 out, 2 in, 3 bidir
  localparam logic [31:0] ALT_KIND          = 32'hff5f_9f90;
  localparam logic [1:0]  KIND_NONE         = 2'h0;
  localparam logic [1:0]  KIND_OUT          = 2'h1;
  localparam logic [1:0]  KIND_IN           = 2'h2;
  localparam logic [1:0]  KIND_BIDIR        = 2'h3;
endpackage

// [design/gfm_loopclk_div.sv]
// divider for the loop clock pin output, driven by loop clock enable pulses
`timescale 1ns/100ps
module gfm_loopclk_div
  import gfm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       loop_tick,
  input  wire logic       enable,
  input  wire logic [6:0] divider,
  output logic            clk_out
);
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic       out_q;
  logic       out_d;
  logic [6:0] half;

  // output high for the first half of each divider period
  always_comb begin
    half  = divider >> 1;
    cnt_d = cnt_q;
    out_d = out_q;
    if (!enable) begin
      cnt_d = 7'h00;
      out_d = 1'b0;
    end else if (loop_tick) begin
      if (cnt_q >= divider - 7'h01) begin
        cnt_d = 7'h00;
      end else begin
        cnt_d = cnt_q + 7'h01;
      end
      out_d = (cnt_d < half);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 7'h00;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign clk_out = out_q;
endmodule

// [design/gfm_edge_flags.sv]
// rising and falling edge flags latched on each debounced pin input
`timescale 1ns/100ps
module gfm_edge_flags
  import gfm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] level,
  input  wire logic [31:0] clear,
  output logic [31:0]      flags
);
  logic [15:0] prev_q;
  logic [15:0] prev_d;
  logic [31:0] flag_q;
  logic [31:0] flag_d;
  logic        primed_q;

  // low half rising, high half falling; a new edge beats a clear
  always_comb begin
    prev_d = level;
    flag_d = flag_q & ~clear;
    if (primed_q) begin
      flag_d = flag_d | {prev_q & ~level, ~prev_q & level};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q   <= 16'h0000;
      flag_q   <= 32'h0000_0000;
      primed_q <= 1'b0;
    end else begin
      prev_q   <= prev_d;
      flag_q   <= flag_d;
      primed_q <= 1'b1;
    end
  end

  assign flags = flag_q;
endmodule

// [testbench/gfm_top_sva.sv]
// assertions on the ports of the pin multiplexer top
`timescale 1ns/100ps
module gfm_chk
  import gfm_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        RSTN,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [15:0] PIN_OE_N,
  input wire logic [15:0] PIN_DEBOUNCED,
  input wire logic        INTERRUPT_REQUEST_ONE_IN,
  input wire logic        IRQ_PIN
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  logic rd_done;
  assign rd_done = PREADY && !PWRITE;
  sequence s_take;
    PSEL && PENABLE && !PREADY;
  endsequence
  sequence s_answer;
    PREADY ##1 !PREADY;
  endsequence
  chk_apb_answer: assert property (s_take |=> s_answer)
    else $error("apb answer missing or too long");
  chk_err_unmapped: assert property (PREADY && PADDR == 16'h0ffc |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not refused");
  chk_err_only_ready: assert property (PSLVERR |-> PREADY)
    else $error("error flag outside answer");
  chk_mapped_ok: assert property (PREADY && PADDR == ADDR_LOOPCLK |-> !PSLVERR)
    else $error("mapped access refused");
  chk_lvl_hidden: assert property (
    rd_done && PADDR >= ADDR_PIN_BASE && PADDR <= 16'h0c44 |-> !PRDATA[POS_LVL])
    else $error("level bit visible on read");
  chk_status_read: assert property (
    rd_done && PADDR == ADDR_STATUS && $stable(PIN_DEBOUNCED)
    && $past(PIN_DEBOUNCED) == $past(PIN_DEBOUNCED, 2) |-> PRDATA[15:0] == PIN_DEBOUNCED)
    else $error("status differs from debounced level");
  chk_irq_follow: assert property ($changed(INTERRUPT_REQUEST_ONE_IN) |=> IRQ_PIN == $past(INTERRUPT_REQUEST_ONE_IN))
    else $error("interrupt pin does not follow");
  chk_reset_input: assert property ($rose(RSTN) |-> PIN_OE_N == 16'hffff)
    else $error("pins driven after reset");
endmodule

// [testbench/gfm_pin_world.sv]
// external circuits on the pins: they drive wherever the device lets go
`timescale 1ns/100ps
module gfm_pin_world
  import gfm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [15:0] ext_level,
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe_n,
  output logic [15:0]      pin_raw,
  output logic [15:0]      pin_db
);
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      pin_raw[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
    end
  end
  // one stage stands in for the debouncer; real filter time is not modelled
  always_ff @(posedge clk) begin
    pin_db <= pin_raw;
  end
endmodule

// [testbench/tb_gfm_top.sv]
// bench for the pin multiplexer: registers, routing, inputs, loop clock
`timescale 1ns/100ps
module tb_gfm_top
  import gfm_pkg::*;
;
  logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, loop_tick = 0;
  logic [15:0] paddr = 0, alt_out = 0, alt_oe = 0, dsp_out = 0, dsp_oe = 0, ext = 0;
  logic [31:0] pwdata = 0, prdata, rdata;
  logic        pready, pslverr, irq_pin, rerr, last;
  logic [15:0] pin_out, oe_n, pin_raw, pin_db, odr;
  logic [19:0] src = 0;
  int          err_count = 0, checks = 0, cyc = 0, hi, rise;
  localparam logic [9:0] CD [20] = '{10'h003, 10'h018, 10'h048, 10'h080, 10'h081, 10'h08c,
    10'h090, 10'h092, 10'h158, 10'h230, 10'h231, 10'h232, 10'h233, 10'h250, 10'h251,
    10'h608, 10'h609, 10'h60a, 10'h60b, 10'h3ff};
  localparam int GP [20] = '{0, 0, 0, 1, 1, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 2, 2, 2, 2, 3};
  gfm_top dut_u (.CLK_SYS(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PIN_IN(pin_raw), .PIN_OUT(pin_out), .PIN_OE_N(oe_n), .PIN_ODRAIN(odr),
    .PIN_DEBOUNCED(pin_db), .ALT_OUT(alt_out), .ALT_OE(alt_oe), .DSP_OUT(dsp_out),
    .DSP_OE(dsp_oe), .INTERRUPT_REQUEST_ONE_IN(src[0]), .IRQ_PIN(irq_pin), .LOOP_TICK(loop_tick),
    .LOOP_LOCK(src[1]), .SYSCLK_OUT_IN(src[2]), .PWM_IN(src[4:3]), .SIGDET_IN(src[5]),
    .US_DET_IN(src[7:6]), .EVLOG_NOT_EMPTY(src[8]), .ALARM_PULSE(src[12:9]),
    .TIMER_PULSE(src[14:13]), .SLAVE_SEL(src[18:15]));
  gfm_pin_world world_u (.clk(clk), .ext_level(ext), .pin_out(pin_out), .pin_oe_n(oe_n),
    .pin_raw(pin_raw), .pin_db(pin_db));
  always #2.5 clk = ~clk;
  task automatic stop_test();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // hang guard, far above the several hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so a following call never re-drives psel in this time step
    @(posedge clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [15:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic count_out(input int n);
    hi = 0;
    rise = 0;
    last = pin_out[0];
    repeat (n) begin
      @(posedge clk);
      hi += int'(pin_out[0]);
      rise += int'(pin_out[0] && !last);
      last = pin_out[0];
    end
  endtask
  task automatic t_reset();
    chk("pins released", 32'h0000_ffff, 32'(oe_n));
    rd(ADDR_PIN_BASE);
    chk("pin1 ctrl", 32'h8000_0001, rdata);
    rd(ADDR_LOOPCLK);
    chk("loop ctrl", 32'h0000_0c04, rdata);
    rd(16'h0ffc);
    chk("unmapped err", 32'h1, 32'(rerr));
  endtask
  task automatic t_gpio();
    wr(ADDR_PIN_BASE, 32'h0000_8001);
    wt(3);
    chk("pin1 out", 32'h1, 32'({oe_n[0], pin_out[0]}));
    rd(ADDR_PIN_BASE);
    chk("pin1 level hidden", 32'h0000_0001, rdata);
    wr(ADDR_PIN_BASE, 32'h0000_d001);
    wt(3);
    chk("pin1 inverted", 32'h0, 32'(pin_out[0]));
    chk("pin1 open drain", 32'h1, 32'(odr[0]));
  endtask
  task automatic t_codes();
    int p[3] = '{0, 8, 10};
    logic e;
    for (int i = 0; i < 20; i++) begin
      foreach (p[k]) wr(ADDR_PIN_BASE + 16'(4 * p[k]), {22'h0, CD[i]});
      src <= (i == 19) ? 20'hfffff : 20'h1 << i;
      wt(3);
      foreach (p[k]) begin
        e = GP[i] == 1 || (GP[i] == 0 && p[k] < 8) || (GP[i] == 2 && p[k] < 10);
        chk($sformatf("code %h pin %0d", CD[i], p[k] + 1), 32'(e), 32'(pin_out[p[k]]));
      end
      if (i == 0) chk("irq pin", 32'h1, 32'(irq_pin));
      src <= 20'h0;
      wt(3);
      chk("codes idle", 32'h0, 32'({pin_out[10], pin_out[8], pin_out[0]}));
    end
  endtask
  task automatic t_alt();
    alt_out <= 16'hffff;
    dsp_out <= 16'hffff;
    dsp_oe <= 16'hffff;
    for (int p = 0; p < 4; p++) wr(ADDR_PIN_BASE + 16'(4 * p), 32'h0000_5000);
    wr(ADDR_PIN_BASE + 16'h10, 32'h8000_5002);
    wt(3);
    chk("alt dirs", 32'h0b, 32'(oe_n[4:0]));
    chk("alt cmos", 32'h0, 32'(odr[4:0]));
    chk("alt dsp out", 32'h3, 32'({pin_out[4], pin_out[2]}));
    dsp_oe <= 16'h0;
    alt_out <= 16'h0;
    wt(3);
    chk("alt follow", 32'h2, 32'({oe_n[4], pin_out[2]}));
  endtask
  task automatic t_inputs();
    ext <= 16'ha5c3;
    alt_oe <= 16'hffff;
    wr(ADDR_PIN_BASE + 16'h14, 32'h8000_1001);
    wt(4);
    rd(ADDR_STATUS);
    // pins 9 and 11 still drive the low of an invalid code
    chk("status", 32'h0000_a0c0, rdata & 32'h0000_ffe0);
    wr(ADDR_EDGE_FLAGS, 32'hffff_ffff);
    ext[6] <= 1'b0;
    wt(4);
    ext[6] <= 1'b1;
    wt(4);
    rd(ADDR_EDGE_FLAGS);
    chk("edge flags", 32'h0040_0040, rdata);
    wr(ADDR_EDGE_FLAGS, 32'h0040_0000);
    rd(ADDR_EDGE_FLAGS);
    chk("fall cleared", 32'h0000_0040, rdata);
  endtask
  task automatic t_loop();
    wr(ADDR_PIN_BASE, 32'h0000_0010);
    loop_tick <= 1'b1;
    for (int d = 2; d <= 4; d += 2) begin
      wr(ADDR_LOOPCLK, 32'(d << 1));
      wr(ADDR_LOOPCLK, 32'(d << 1) | 32'h1);
      wt(8);
      count_out(40);
      chk("loop highs", 32'h14, 32'(hi));
      chk("loop rises", 32'(40 / d), 32'(rise));
      wr(ADDR_LOOPCLK, 32'(d << 1));
    end
    wr(ADDR_LOOPCLK, 32'h0000_0008);
    wt(4);
    count_out(20);
    chk("loop gated", 32'h0, 32'(hi));
  endtask
  initial begin
    wt(10);
    rstn <= 1'b1;
    wt(1);
    t_reset();
    t_gpio();
    t_codes();
    t_alt();
    t_inputs();
    t_loop();
    stop_test();
  end
endmodule
bind gfm_top gfm_chk chk_u (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .PIN_OE_N(PIN_OE_N), .PIN_DEBOUNCED(PIN_DEBOUNCED), .INTERRUPT_REQUEST_ONE_IN(INTERRUPT_REQUEST_ONE_IN), .IRQ_PIN(IRQ_PIN));
